// file: rtl/slslk_defines.vh
// Purpose: shared constants of the polled serial slave link
// Assumes: 25 MHz ref_clk, word-wide plain register port
// Notes: offsets are register indices on reg_addr
`ifndef SLSLK_DEFINES_VH
`define SLSLK_DEFINES_VH

// ----------------------------------------
// clock and time bases
// ----------------------------------------
`define SLSLK_CLK_HZ 25000000
`define SLSLK_TICK_US 5000
`define SLSLK_T5_CYC ((`SLSLK_CLK_HZ / 1000000) * `SLSLK_TICK_US)
`define SLSLK_T20_PER_T5 2'h3
`define SLSLK_CTS_WIN_MS 1000
`define SLSLK_CTS_WIN_TICKS 8'd200

// ----------------------------------------
// register indices
// ----------------------------------------
`define SLSLK_REG_CTRL 4'h0
`define SLSLK_REG_STATION 4'h1
`define SLSLK_REG_DELAY 4'h2
`define SLSLK_REG_POLL 4'h3
`define SLSLK_REG_MSG 4'h4
`define SLSLK_REG_STATUS 4'h5
`define SLSLK_REG_MASK 4'h6

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SLSLK_CTRL_MODEM 3
`define SLSLK_CTRL_BCC 4
`define SLSLK_CTRL_DUPOFF 5
`define SLSLK_CTRL_SILENT 6
`define SLSLK_BAUD_9600 3'h5
`define SLSLK_STATION_RST 8'h01
`define SLSLK_BROADCAST 8'hff
`define SLSLK_POLLTO_RST 16'h0bb8
`define SLSLK_RETRY_RST 8'h03

// ----------------------------------------
// status bits
// ----------------------------------------
`define SLSLK_EV_RXDATA 0
`define SLSLK_EV_DONE 1
`define SLSLK_EV_POLLTO 2
`define SLSLK_EV_FAIL 3
`define SLSLK_EV_CTS 4
`define SLSLK_EV_CHK 5
`define SLSLK_EV_W 6

// ----------------------------------------
// frame commands
// ----------------------------------------
`define SLSLK_CMD_POLL 8'h01
`define SLSLK_CMD_DATA 8'h02
`define SLSLK_CMD_ACK 8'h03
`define SLSLK_CMD_NAK 8'h04
`define SLSLK_CMD_END 8'h05
`define SLSLK_CRC_POLY 16'ha001

`endif

// file: rtl/slslk_tick.v
// Purpose: 5 ms and 20 ms tick prescaler
// Assumes: T5_CYC cycles per 5 ms
// Notes: ticks are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "slslk_defines.vh"

module slslk_tick #(
	parameter T5_CYC = `SLSLK_T5_CYC
) (
	input wire ref_clk,
	input wire sys_rst,
	output reg tick5,
	output reg tick20
);
	reg [23:0] cnt; // cycle counter within 5 ms
	reg [1:0] quarter; // 5 ms ticks within 20 ms
	localparam integer LAST_I = T5_CYC - 1; // full-width count before the cut
	localparam [23:0] LAST = LAST_I[23:0];

	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt <= 24'h00_0000;
			quarter <= 2'h0;
			tick5 <= 1'b0;
			tick20 <= 1'b0;
		end else begin
			tick5 <= (cnt == LAST);
			tick20 <= (cnt == LAST) && (quarter == `SLSLK_T20_PER_T5);
			if (cnt == LAST) begin
				cnt <= 24'h00_0000;
				quarter <= quarter + 2'h1;
			end else begin
				cnt <= cnt + 24'h00_0001;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/slslk_uart.v
// Purpose: byte serialiser and deserialiser, 8N1
// Assumes: rxd synchronous to ref_clk
// Notes: tx_go only while tx_ready is high
`timescale 1ns/1ps
`default_nettype none
`include "slslk_defines.vh"

module slslk_uart #(
	parameter CLK_HZ = `SLSLK_CLK_HZ
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire [2:0] baud_sel,
	input wire tx_go,
	input wire [7:0] tx_data,
	output reg tx_ready,
	output reg txd,
	input wire rxd,
	output reg rx_valid,
	output reg [7:0] rx_data
);
	localparam integer D0 = CLK_HZ / 300;
	localparam integer D1 = CLK_HZ / 600;
	localparam integer D2 = CLK_HZ / 1200;
	localparam integer D3 = CLK_HZ / 2400;
	localparam integer D4 = CLK_HZ / 4800;
	localparam integer D5 = CLK_HZ / 9600;
	localparam integer D6 = CLK_HZ / 19200;
	localparam integer D7 = CLK_HZ / 38400;
	reg [16:0] div; // cycles per bit
	reg [16:0] tx_cnt;
	reg [3:0] tx_bit;
	reg [8:0] tx_sh; // stop bit above data
	reg rx_busy;
	reg [16:0] rx_cnt; // down counter to next sample
	reg [3:0] rx_bit;
	reg [7:0] rx_sh;

	// ----------------------------------------
	// rate select
	// ----------------------------------------
	always @* begin
		case (baud_sel)
			3'h0: div = D0[16:0];
			3'h1: div = D1[16:0];
			3'h2: div = D2[16:0];
			3'h3: div = D3[16:0];
			3'h4: div = D4[16:0];
			3'h6: div = D6[16:0];
			3'h7: div = D7[16:0];
			default: div = D5[16:0];
		endcase
	end

	// ----------------------------------------
	// transmitter: start, 8 data lsb first, stop
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_ready <= 1'b1;
			txd <= 1'b1;
			tx_cnt <= 17'h0_0000;
			tx_bit <= 4'h0;
			tx_sh <= 9'h1ff;
		end else if (tx_ready) begin
			if (tx_go) begin
				tx_ready <= 1'b0;
				txd <= 1'b0;
				tx_sh <= {1'b1, tx_data};
				tx_cnt <= 17'h0_0000;
				tx_bit <= 4'h0;
			end
		end else if (tx_cnt == div - 17'h0_0001) begin
			tx_cnt <= 17'h0_0000;
			if (tx_bit == 4'h9) begin
				tx_ready <= 1'b1; // stop bit fully sent
			end else begin
				txd <= tx_sh[0];
				tx_sh <= {1'b1, tx_sh[8:1]};
				tx_bit <= tx_bit + 4'h1;
			end
		end else begin
			tx_cnt <= tx_cnt + 17'h0_0001;
		end
	end

	// ----------------------------------------
	// receiver: mid-bit sampling
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_busy <= 1'b0;
			rx_cnt <= 17'h0_0000;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy) begin
				if (!rxd) begin
					rx_busy <= 1'b1;
					rx_cnt <= {1'b0, div[16:1]};
					rx_bit <= 4'h0;
				end
			end else if (rx_cnt != 17'h0_0000) begin
				rx_cnt <= rx_cnt - 17'h0_0001;
			end else if (rx_bit == 4'h0) begin
				// glitch on the start bit is dropped
				rx_busy <= ~rxd;
				rx_cnt <= div - 17'h0_0001;
				rx_bit <= 4'h1;
			end else if (rx_bit != 4'h9) begin
				rx_sh <= {rxd, rx_sh[7:1]};
				rx_cnt <= div - 17'h0_0001;
				rx_bit <= rx_bit + 4'h1;
			end else begin
				rx_busy <= 1'b0;
				rx_valid <= rxd; // framing error drops the byte
				rx_data <= rx_sh;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/slslk_core.v
// Purpose: slave end of a polled multi-drop half-duplex serial link
// Assumes: frame = station, command, tag, check (crc lsb first, or bcc)
// Notes: all delays counted in whole 5 ms or 20 ms ticks
`timescale 1ns/1ps
`default_nettype none
`include "slslk_defines.vh"

module slslk_core #(
	parameter T5_CYC = `SLSLK_T5_CYC
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output reg irq,
	input wire rxd,
	output wire txd,
	output reg rts,
	input wire cts
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	localparam [2:0] S_IDLE = 3'h0, S_PRE = 3'h1, S_KEY = 3'h2;
	localparam [2:0] S_CTS = 3'h3, S_SEND = 3'h4, S_HOLD = 3'h5;
	reg [2:0] baud_sel; // line rate choice
	reg modem, use_bcc, dup_off, silent; // control bits
	reg [7:0] station; // own address
	reg [7:0] off_dly, key_dly, pre_dly; // 5 ms units
	reg [15:0] poll_to; // 20 ms units
	reg [7:0] retries;
	reg [`SLSLK_EV_W-1:0] status, mask;
	reg msg_q; // queued, awaiting poll
	reg msg_ack; // sent, awaiting ack
	reg [7:0] msg_tag, retry_cnt, rx_tag_last, rx_tag_prev;
	reg have_prev; // a data tag has been seen
	reg [15:0] poll_cnt;
	reg [2:0] state;
	reg [7:0] dly_cnt, cts_cnt;
	reg [7:0] tx_cmd, tx_tag;
	reg [2:0] tx_idx;
	reg tx_go;
	reg [7:0] tx_byte;
	reg [2:0] rx_idx;
	reg [7:0] rx_b0, rx_b1, rx_b2, rx_c0;
	reg rx_seen; // byte since last tick
	reg [`SLSLK_EV_W-1:0] ev; // events this cycle
	reg start_tx; // poll answer decided
	reg [7:0] start_cmd;
	wire tick5, tick20, tx_ready, rx_valid;
	wire [7:0] rx_data;
	wire [2:0] flen = use_bcc ? 3'h4 : 3'h5;
	wire [15:0] rx_crc = crc_b(crc_b(crc_b(16'h0000, rx_b0), rx_b1), rx_b2);
	wire [7:0] rx_bcc = 8'h00 - (rx_b0 + rx_b1 + rx_b2);
	wire [15:0] tx_crc = crc_b(crc_b(crc_b(16'h0000, station), tx_cmd), tx_tag);
	wire [7:0] tx_bcc = 8'h00 - (station + tx_cmd + tx_tag);
	wire frame_end = rx_valid && (rx_idx == flen - 3'h1);
	wire chk_ok = use_bcc ? (rx_data == rx_bcc) : ({rx_data, rx_c0} == rx_crc);
	wire for_us = (rx_b0 == station);
	wire bcast = (rx_b0 == `SLSLK_BROADCAST);
	wire idle_now = (state == S_IDLE);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [15:0] crc_b;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] t;
		begin
			t = c ^ {8'h00, d};
			for (i = 0; i < 8; i = i + 1) begin
				t = t[0] ? ((t >> 1) ^ `SLSLK_CRC_POLY) : (t >> 1);
			end
			crc_b = t;
		end
	endfunction

	slslk_tick #(.T5_CYC(T5_CYC)) u_tick (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.tick5(tick5),
		.tick20(tick20)
	);

	slslk_uart #(.CLK_HZ(`SLSLK_CLK_HZ)) u_uart (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.baud_sel(baud_sel),
		.tx_go(tx_go),
		.tx_data(tx_byte),
		.tx_ready(tx_ready),
		.txd(txd),
		.rxd(rxd),
		.rx_valid(rx_valid),
		.rx_data(rx_data)
	);

	// ----------------------------------------
	// poll decision, combinational
	// ----------------------------------------
	always @* begin
		start_tx = 1'b0;
		start_cmd = `SLSLK_CMD_END;
		// only a poll or nak addressed to us opens a turn; broadcast never answered
		if (frame_end && chk_ok && for_us && idle_now) begin
			if (rx_b1 == `SLSLK_CMD_POLL || rx_b1 == `SLSLK_CMD_NAK) begin
				if (msg_ack && retry_cnt != retries) begin
					start_tx = 1'b1;
					start_cmd = `SLSLK_CMD_DATA;
				end else if (msg_q && rx_b1 == `SLSLK_CMD_POLL) begin
					start_tx = 1'b1;
					start_cmd = `SLSLK_CMD_DATA;
				end else if (!msg_ack && rx_b1 == `SLSLK_CMD_POLL && !silent) begin
					start_tx = 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// receive framing
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_idx <= 3'h0;
			rx_b0 <= 8'h00;
			rx_b1 <= 8'h00;
			rx_b2 <= 8'h00;
			rx_c0 <= 8'h00;
			rx_seen <= 1'b0;
		end else if (rx_valid) begin
			rx_seen <= 1'b1;
			case (rx_idx)
				3'h0: rx_b0 <= rx_data;
				3'h1: rx_b1 <= rx_data;
				3'h2: rx_b2 <= rx_data;
				default: rx_c0 <= rx_data;
			endcase
			rx_idx <= frame_end ? 3'h0 : rx_idx + 3'h1;
		end else if (tick5) begin
			// a silent tick inside a frame resynchronises to the next byte
			rx_seen <= 1'b0;
			if (!rx_seen) begin
				rx_idx <= 3'h0;
			end
		end
	end

	// ----------------------------------------
	// transmit sequencer
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= S_IDLE;
			dly_cnt <= 8'h00;
			cts_cnt <= 8'h00;
			rts <= 1'b0;
			tx_cmd <= `SLSLK_CMD_END;
			tx_tag <= 8'h00;
			tx_idx <= 3'h0;
			tx_go <= 1'b0;
			tx_byte <= 8'h00;
		end else begin
			tx_go <= 1'b0;
			case (state)
				S_IDLE: begin
					if (start_tx) begin
						tx_cmd <= start_cmd;
						tx_tag <= (start_cmd == `SLSLK_CMD_DATA) ? msg_tag : 8'h00;
						dly_cnt <= 8'h00;
						state <= S_PRE;
					end
				end
				S_PRE: begin
					if (dly_cnt == pre_dly) begin
						dly_cnt <= 8'h00;
						cts_cnt <= 8'h00;
						rts <= modem;
						state <= modem ? S_KEY : S_SEND;
						tx_idx <= 3'h0;
					end else if (tick5) begin
						dly_cnt <= dly_cnt + 8'h01;
					end
				end
				S_KEY: begin
					if (tick5) begin
						cts_cnt <= cts_cnt + 8'h01;
					end
					if (dly_cnt == key_dly) begin
						state <= S_CTS;
					end else if (tick5) begin
						dly_cnt <= dly_cnt + 8'h01;
					end
				end
				S_CTS: begin
					if (cts) begin
						state <= S_SEND;
					end else if (cts_cnt >= `SLSLK_CTS_WIN_TICKS) begin
						rts <= 1'b0;
						state <= S_IDLE;
					end else if (tick5) begin
						cts_cnt <= cts_cnt + 8'h01;
					end
				end
				S_SEND: begin
					if (tx_ready && !tx_go) begin
						if (tx_idx == flen) begin
							dly_cnt <= 8'h00;
							state <= modem ? S_HOLD : S_IDLE;
						end else begin
							tx_go <= 1'b1;
							tx_idx <= tx_idx + 3'h1;
							case (tx_idx)
								3'h0: tx_byte <= station;
								3'h1: tx_byte <= tx_cmd;
								3'h2: tx_byte <= tx_tag;
								3'h3: tx_byte <= use_bcc ? tx_bcc : tx_crc[7:0];
								default: tx_byte <= tx_crc[15:8];
							endcase
						end
					end
				end
				S_HOLD: begin
					if (dly_cnt == off_dly) begin
						rts <= 1'b0;
						state <= S_IDLE;
					end else if (tick5) begin
						dly_cnt <= dly_cnt + 8'h01;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// message bookkeeping and events
	// ----------------------------------------
	always @* begin
		ev = {`SLSLK_EV_W{1'b0}};
		ev[`SLSLK_EV_CTS] = (state == S_CTS) && !cts && (cts_cnt >= `SLSLK_CTS_WIN_TICKS);
		ev[`SLSLK_EV_CHK] = frame_end && !chk_ok;
		ev[`SLSLK_EV_RXDATA] = frame_end && chk_ok && (for_us || bcast)
			&& (rx_b1 == `SLSLK_CMD_DATA)
			&& !(!dup_off && have_prev && rx_b2 == rx_tag_prev);
		ev[`SLSLK_EV_DONE] = frame_end && chk_ok && for_us && msg_ack
			&& (rx_b1 == `SLSLK_CMD_ACK);
		ev[`SLSLK_EV_FAIL] = frame_end && chk_ok && for_us && msg_ack && idle_now
			&& (rx_b1 == `SLSLK_CMD_POLL || rx_b1 == `SLSLK_CMD_NAK)
			&& (retry_cnt == retries);
		ev[`SLSLK_EV_POLLTO] = msg_q && (poll_to != 16'h0000) && (poll_cnt == poll_to);
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			msg_q <= 1'b0;
			msg_ack <= 1'b0;
			msg_tag <= 8'h00;
			retry_cnt <= 8'h00;
			poll_cnt <= 16'h0000;
			rx_tag_last <= 8'h00;
			rx_tag_prev <= 8'h00;
			have_prev <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `SLSLK_REG_MSG && reg_wdata[0] && !msg_q && !msg_ack) begin
				msg_q <= 1'b1;
				msg_tag <= reg_wdata[15:8];
				poll_cnt <= 16'h0000;
			end else if (ev[`SLSLK_EV_POLLTO]) begin
				msg_q <= 1'b0;
			end else if (msg_q && start_tx && start_cmd == `SLSLK_CMD_DATA) begin
				msg_q <= 1'b0;
				msg_ack <= 1'b1;
				retry_cnt <= 8'h00;
			end else if (msg_q && tick20) begin
				poll_cnt <= poll_cnt + 16'h0001;
			end
			if (msg_ack && start_tx && start_cmd == `SLSLK_CMD_DATA) begin
				retry_cnt <= retry_cnt + 8'h01;
			end
			if (ev[`SLSLK_EV_DONE] || ev[`SLSLK_EV_FAIL]) begin
				msg_ack <= 1'b0;
			end
			if (frame_end && chk_ok && (for_us || bcast) && rx_b1 == `SLSLK_CMD_DATA) begin
				rx_tag_prev <= rx_b2;
				have_prev <= 1'b1;
			end
			if (ev[`SLSLK_EV_RXDATA]) begin
				rx_tag_last <= rx_b2;
			end
		end
	end

	// ----------------------------------------
	// register writes, sticky status
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			baud_sel <= `SLSLK_BAUD_9600;
			modem <= 1'b0;
			use_bcc <= 1'b0;
			dup_off <= 1'b0;
			silent <= 1'b0;
			station <= `SLSLK_STATION_RST;
			off_dly <= 8'h00;
			key_dly <= 8'h00;
			pre_dly <= 8'h00;
			poll_to <= `SLSLK_POLLTO_RST;
			retries <= `SLSLK_RETRY_RST;
			status <= {`SLSLK_EV_W{1'b0}};
			mask <= {`SLSLK_EV_W{1'b0}};
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
			// a new event wins over a same-cycle clear
			if (reg_wr && reg_addr == `SLSLK_REG_STATUS) begin
				status <= (status & ~reg_wdata[`SLSLK_EV_W-1:0]) | ev;
			end else begin
				status <= status | ev;
			end
			if (reg_wr) begin
				case (reg_addr)
					`SLSLK_REG_CTRL: begin
						baud_sel <= reg_wdata[2:0];
						modem <= reg_wdata[`SLSLK_CTRL_MODEM];
						use_bcc <= reg_wdata[`SLSLK_CTRL_BCC];
						dup_off <= reg_wdata[`SLSLK_CTRL_DUPOFF];
						silent <= reg_wdata[`SLSLK_CTRL_SILENT];
					end
					`SLSLK_REG_STATION: begin
						if (reg_wdata[7:0] != `SLSLK_BROADCAST) begin
							station <= reg_wdata[7:0];
						end
					end
					`SLSLK_REG_DELAY: begin
						off_dly <= reg_wdata[7:0];
						key_dly <= reg_wdata[15:8];
						pre_dly <= reg_wdata[23:16];
					end
					`SLSLK_REG_POLL: begin
						poll_to <= reg_wdata[15:0];
						retries <= reg_wdata[23:16];
					end
					`SLSLK_REG_MASK: mask <= reg_wdata[`SLSLK_EV_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// register reads, data one cycle later
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`SLSLK_REG_CTRL: reg_rdata <= {25'h000_0000, silent, dup_off, use_bcc, modem, baud_sel};
				`SLSLK_REG_STATION: reg_rdata <= {24'h00_0000, station};
				`SLSLK_REG_DELAY: reg_rdata <= {8'h00, pre_dly, key_dly, off_dly};
				`SLSLK_REG_POLL: reg_rdata <= {8'h00, retries, poll_to};
				`SLSLK_REG_MSG: reg_rdata <= {rx_tag_last, 5'h00, state, msg_tag, 6'h00, msg_ack, msg_q};
				`SLSLK_REG_STATUS: reg_rdata <= {26'h000_0000, status};
				`SLSLK_REG_MASK: reg_rdata <= {26'h000_0000, mask};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// file: tb/slslk_core_sva.sv
// Purpose: port-level checks of the polled serial slave link core
// Assumes: one ref_clk domain, synchronous active-high sys_rst
// Notes: ctrl and mask are shadowed from bus writes, not read back
`timescale 1ns/1ps
`default_nettype none
module slslk_core_sva #(
	parameter T5_CYC = 125000
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic irq,
	input wire logic rxd,
	input wire logic txd,
	input wire logic rts,
	input wire logic cts
);
	// ----------------------------------------
	// shadow state
	// ----------------------------------------
	localparam int CTS_LIM = 202 * T5_CYC; // window plus tick phase slack
	logic modem_on; // handshake mode as last written
	logic [31:0] mask_r; // irq mask as last written
	logic [31:0] no_cts; // cycles rts has waited for cts
	logic seen_rx; // any line activity from the master yet
	// shadows follow bus writes so the checker needs no read port
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			modem_on <= 1'h0;
			mask_r <= 32'h0000_0000;
			no_cts <= 32'h0000_0000;
			seen_rx <= 1'h0;
		end else begin
			if (reg_wr && reg_addr == 4'h0)
				modem_on <= reg_wdata[3];
			if (reg_wr && reg_addr == 4'h6)
				mask_r <= reg_wdata;
			no_cts <= (rts && !cts) ? no_cts + 32'h0000_0001 : 32'h0000_0000;
			if (!rxd)
				seen_rx <= 1'h1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	chk_reset_idle: assert property ($past(sys_rst) |-> txd && !rts && !irq)
		else $error("line not idle after reset");
	chk_station_range: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:0] != 8'hff && reg_rdata[31:8] == 24'h00_0000)
		else $error("station address out of range");
	chk_unmapped_read: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped index read nonzero");
	chk_plain_no_rts: assert property (!modem_on |-> !rts)
		else $error("rts raised without modem mode");
	chk_tx_needs_cts: assert property (modem_on && $fell(txd) |-> rts && cts)
		else $error("modem transmit without rts and cts");
	chk_keyup_gap: assert property ($rose(rts) |=> txd [*8])
		else $error("transmit started with rts");
	chk_rts_release: assert property ($fell(rts) |-> txd)
		else $error("rts dropped mid character");
	chk_cts_window: assert property (no_cts <= CTS_LIM)
		else $error("rts kept waiting for cts too long");
	chk_tx_after_poll: assert property (!txd |-> seen_rx)
		else $error("transmit before any master traffic");
	chk_irq_masked: assert property ($past(mask_r) == 32'h0000_0000 |-> !irq)
		else $error("irq with all events masked");
endmodule
`default_nettype wire

// file: tb/slslk_master_model.sv
// Purpose: polling master station with a half-duplex modem
// Assumes: 8N1 lsb first at BIT_CYC cycles per bit
// Notes: bytes seen on txd are queued in rx_q for the bench
`timescale 1ns/1ps
`default_nettype none
module slslk_master_model #(
	parameter BIT_CYC = 651
) (
	input wire logic ref_clk,
	output logic rxd,
	input wire logic txd,
	input wire logic rts,
	output logic cts
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] rx_q [$]; // reply bytes caught on txd
	logic [15:0] key_sr = 16'h0000; // modem key-up lag
	logic [7:0] b; // byte being caught
	integer i;
	// cts and key_sr belong to the clocked process alone
	initial begin
		rxd = 1'h1;
	end
	// modem raises cts a while after rts, drops it with rts
	always @(posedge ref_clk) begin
		key_sr <= {key_sr[14:0], rts};
		cts <= rts && key_sr[15];
	end
	// one character, line left idle high afterwards
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] f;
		integer k;
		f = {1'h1, d, 1'h0};
		for (k = 0; k < 10; k++) begin
			@(posedge ref_clk);
			rxd <= f[k];
			repeat (BIT_CYC - 1) @(posedge ref_clk);
		end
	endtask
	// catch reply bytes, sampling mid-bit
	initial begin
		forever begin
			@(negedge txd);
			repeat (BIT_CYC / 2) @(posedge ref_clk);
			for (i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge ref_clk);
				b[i] = txd;
			end
			repeat (BIT_CYC) @(posedge ref_clk);
			rx_q.push_back(b);
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_polled_serial_slave_link.sv
// Purpose: self-checking bench of the slave link core
// Assumes: T5 shortened to just over one character at 38400
// Notes: one poll round trip in modem and bcc mode
`timescale 1ns/1ps
`default_nettype none
module tb_polled_serial_slave_link;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int T5 = 7000; // above one byte time, else mid-frame resync
	logic ref_clk, sys_rst, reg_wr, reg_rd, rxd, txd, rts, cts, irq;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_val;
	integer errors = 0, checked = 0, n;
	// reset rows: index beside expected word
	logic [35:0] rows [8] = '{36'h0_0000_0005, 36'h1_0000_0001, 36'h2_0000_0000,
		36'h3_0003_0bb8, 36'h4_0000_0000, 36'h5_0000_0000, 36'h6_0000_0000, 36'h7_0000_0000};
	slslk_core #(.T5_CYC(T5)) slslk_core_i (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .irq, .rxd, .txd, .rts, .cts);
	slslk_master_model #(.BIT_CYC(651)) slslk_master_model_i (.ref_clk, .rxd, .txd, .rts, .cts);
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, a little above the expected run of about 90000 cycles
	initial begin
		repeat (100000) @(posedge ref_clk);
		errors++;
		print_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'h1;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'h0;
		for (n = 0; n < 8; n++) begin
			rd(rows[n][35:32]);
			check("reset value", rd_val, rows[n][31:0]);
		end
		$display("test reset values done");
		// broadcast address is refused as own station
		wr(4'h1, 32'h0000_00ff);
		rd(4'h1);
		check("station", rd_val, 32'h0000_0001);
		// poll timeout of one 20 ms unit drops the message
		wr(4'h3, 32'h0003_0001);
		wr(4'h6, 32'h0000_0004);
		wr(4'h4, 32'h0000_a501);
		rd(4'h4);
		check("queued", rd_val[1:0], 32'h0000_0001);
		n = 0;
		while (irq !== 1'h1 && n < 40000) begin
			@(posedge ref_clk);
			n++;
		end
		check("timeout irq", irq, 32'h0000_0001);
		check("timeout late", n > 2 * T5, 32'h0000_0001);
		rd(4'h5);
		check("status", rd_val, 32'h0000_0004);
		rd(4'h4);
		check("dropped", rd_val[1:0], 32'h0000_0000);
		wr(4'h5, 32'h0000_0004);
		repeat (3) @(posedge ref_clk);
		check("irq cleared", irq, 32'h0000_0000);
		$display("test poll timeout done");
		// zero timeout never fires
		wr(4'h3, 32'h0003_0000);
		wr(4'h4, 32'h0000_5a01);
		// a zero taken as a real limit would fire at once, so one tick is ample
		repeat (T5) @(posedge ref_clk);
		rd(4'h5);
		check("no timeout", rd_val, 32'h0000_0000);
		$display("test zero timeout done");
		// poll at 38400, modem and bcc, key-up one tick
		wr(4'h0, 32'h0000_001f);
		wr(4'h2, 32'h0000_0100);
		slslk_master_model_i.send_byte(8'h01);
		slslk_master_model_i.send_byte(8'h01);
		slslk_master_model_i.send_byte(8'h00);
		slslk_master_model_i.send_byte(8'hfe);
		n = 0;
		while (slslk_master_model_i.rx_q.size() < 4 && n < 60000) begin
			@(posedge ref_clk);
			n++;
		end
		check("reply length", slslk_master_model_i.rx_q.size(), 32'h0000_0004);
		check("reply station", slslk_master_model_i.rx_q[0], 32'h0000_0001);
		check("reply command", slslk_master_model_i.rx_q[1], 32'h0000_0002);
		check("reply tag", slslk_master_model_i.rx_q[2], 32'h0000_005a);
		check("reply bcc", slslk_master_model_i.rx_q[3], 32'h0000_00a3);
		// off delay 0: rts falls within half a bit after the last stop bit
		repeat (1000) @(posedge ref_clk);
		check("rts released", rts, 32'h0000_0000);
		$display("test poll reply done");
		print_verdict();
	end
endmodule
bind slslk_core slslk_core_sva #(.T5_CYC(T5_CYC)) slslk_core_sva_i (.ref_clk, .sys_rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .rxd, .txd, .rts, .cts);
`default_nettype wire
